// [pmc_defines.svh]
// Constants for the power-mode controller: offsets, fields, resets, timing
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// Register indices; byte address is four times the index
`define PMC_POWER_CONTROL_IDX 8'h87
`define PMC_IRQ_STAT_IDX 8'h88
`define PMC_IRQ_MASK_IDX 8'h89
`define PMC_WAKE_CFG_IDX 8'h8A
`define PMC_STATE_IDX 8'h8B

// Power control fields
`define PMC_IDL_BIT 0
`define PMC_PD_BIT 1
`define PMC_POF_BIT 4
`define PMC_POWER_CONTROL_RST 8'h00
`define PMC_POWER_CONTROL_WMASK 8'hDF

// Interrupt status fields
`define PMC_EVT_W 4
`define PMC_EVT_IDLE_ENTER 0
`define PMC_EVT_PD_ENTER 1
`define PMC_EVT_WAKE 2
`define PMC_EVT_RESET_WAKE 3
`define PMC_IRQ_MASK_RST 4'h0

// Wake configuration fields
`define PMC_CFG_KBD_LSB 0
`define PMC_CFG_BOD_BIT 8
`define PMC_WAKE_CFG_RST 9'h000

// Timing
`define PMC_CLK_NS 100
`define PMC_OSC_STABLE_NS 100000
`define PMC_OSC_STABLE_CYC \
    ((`PMC_OSC_STABLE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)

`endif

// [pmc_pkg.sv]
// Types shared by the power-mode controller
package pmc_pkg;

    typedef enum logic [2:0] {
        PMC_RUN,
        PMC_IDLE,
        PMC_PDOWN,
        PMC_OSC_WAIT,
        PMC_RELEASE
    } pmc_state_t;

    typedef struct packed {
        logic osc_en;
        logic periph_en;
        logic cpu_en;
    } pmc_clk_ctl_t;

    typedef struct packed {
        logic reset;
        logic brownout;
        logic watchdog;
        logic keyboard;
        logic ext_pin;
        logic interrupt;
    } pmc_wake_src_t;

endpackage

// [pmc_power_mode_controller.sv]
// Power-mode controller: idle and power-down entry, wake and clock release
//
// Function
// - Clear watchdog on mode entry and wake
// - Power-down bit stops CPU and peripheral clocks
// - Power-down wake clears bit, resumes execution
// - Both bits set: power-down, no idle after
// - Idle bit stops only CPU clock
// - Idle: no fetch, state and ports held
// - Idle-bit write is last executed instruction
// - Enabled interrupt ends idle, clears idle bit
// - Non-software resets also end idle
// - Power-down stops oscillator, freezes all, holds ports
// - Power-down write is last executed instruction
// - Non-software resets release power-down; brown-out gated
// - Pin or power-on reset wake from power-down reinitialises CPU
// - Enabled external pin wakes, restarts clock
// - Brown-out, watchdog, keyboard also wake power-down
// - Keyboard wake only on edge opposite entry level
// - Power-on sets power-on flag; software clears
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "pmc_defines.svh"

module pmc_power_mode_controller #(
    parameter int ADDR_W = 12,
    parameter int N_IRQ = 8,
    parameter int N_EXT = 2,
    parameter int KBD_W = 8,
    parameter int OSC_STABLE_CYC = `PMC_OSC_STABLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [N_IRQ-1:0] irq_pending_i,
    input wire logic [N_IRQ-1:0] irq_enable_i,
    input wire logic global_interrupt_enable_i,
    input wire logic [N_EXT-1:0] ext_int_n_i,
    input wire logic [N_EXT-1:0] ext_int_en_i,
    input wire logic [KBD_W-1:0] keyboard_interrupt_pin_i,
    input wire logic watchdog_irq_i,
    input wire logic brownout_irq_i,
    input wire logic por_i,
    input wire logic ext_rst_n_i,
    input wire logic watchdog_rst_i,
    input wire logic brownout_rst_i,
    input wire logic sw_rst_i,
    output pmc_pkg::pmc_clk_ctl_t clk_ctl_o,
    output logic port_hold_o,
    output logic flash_stop_o,
    output logic watchdog_counter_clr_o,
    output logic cpu_reinit_o,
    output pmc_pkg::pmc_wake_src_t wake_src_o,
    output logic baud_doubler_o,
    output logic pmc_irq_o
);
    import pmc_pkg::*;

    localparam int SYNC_W = 2 + N_EXT + KBD_W;
    // Idle pin levels, so reset release shows no false reset or pin event
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b0, 1'b1, {N_EXT{1'b1}},
                                               {KBD_W{1'b1}}};
    localparam int CNT_W = $clog2(OSC_STABLE_CYC + 1);

    generate
        if (ADDR_W < 10 || ADDR_W > 32 || N_IRQ < 1 || N_EXT < 1
            || KBD_W < 1 || KBD_W > 8 || OSC_STABLE_CYC < 1)
        begin : g_bad_param
            $error("pmc_power_mode_controller: unsupported parameters");
        end
    endgenerate

    // Pin synchronisers
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic [KBD_W-1:0] kbd_prev_ff;
    logic [KBD_W-1:0] kbd_entry_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_ff <= SYNC_IDLE;
            sync2_ff <= SYNC_IDLE;
        end
        else if (ce_i)
        begin
            sync1_ff <= {por_i, ext_rst_n_i, ext_int_n_i,
                         keyboard_interrupt_pin_i};
            sync2_ff <= sync1_ff;
        end
    end

    logic [KBD_W-1:0] kbd_s;
    logic [N_EXT-1:0] ext_int_n_s;
    logic ext_rst_s;
    logic por_s;

    assign kbd_s = sync2_ff[KBD_W-1:0];
    assign ext_int_n_s = sync2_ff[KBD_W +: N_EXT];
    assign ext_rst_s = ~sync2_ff[KBD_W + N_EXT];
    assign por_s = sync2_ff[KBD_W + N_EXT + 1];

    // Registers
    pmc_state_t state_ff;
    pmc_state_t nxt_state;
    logic [7:0] power_control_ff;
    logic [7:0] nxt_power_control;
    logic [`PMC_EVT_W-1:0] irq_stat_ff;
    logic [`PMC_EVT_W-1:0] nxt_irq_stat;
    logic [`PMC_EVT_W-1:0] irq_mask_ff;
    logic [8:0] wake_cfg_ff;
    logic [CNT_W-1:0] osc_cnt_ff;
    logic reinit_pend_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    pmc_clk_ctl_t clk_ctl_ff;
    logic port_hold_ff;
    logic flash_stop_ff;
    logic wdt_clr_ff;
    logic cpu_reinit_ff;
    pmc_wake_src_t wake_src_ff;
    pmc_wake_src_t nxt_wake_src;
    logic irq_ff;

    // Bus decode
    logic req;
    logic wr;
    logic [7:0] idx;
    logic idx_hit;

    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = req & wb_we_i;
    assign idx = wb_adr_i[9:2];
    assign idx_hit = (wb_adr_i[ADDR_W-1:10] == '0);

    logic power_control_wr;
    logic mask_wr;
    logic stat_wr;
    logic cfg_wr;

    assign power_control_wr = wr & wb_sel_i[0] & idx_hit & (idx == `PMC_POWER_CONTROL_IDX);
    assign stat_wr = wr & wb_sel_i[0] & idx_hit
                     & (idx == `PMC_IRQ_STAT_IDX);
    assign mask_wr = wr & wb_sel_i[0] & idx_hit
                     & (idx == `PMC_IRQ_MASK_IDX);
    assign cfg_wr = wr & idx_hit & (idx == `PMC_WAKE_CFG_IDX);

    // Wake conditions
    logic bod_en;
    logic [KBD_W-1:0] kbd_en;
    logic rst_wake_idle;
    logic rst_wake_pd;
    logic irq_wake;
    logic ext_wake;
    logic kbd_wake;
    logic bod_wake;
    logic idle_wake;
    logic pd_wake;

    assign bod_en = wake_cfg_ff[`PMC_CFG_BOD_BIT];
    assign kbd_en = wake_cfg_ff[`PMC_CFG_KBD_LSB +: KBD_W];
    assign rst_wake_idle = por_s | ext_rst_s | watchdog_rst_i
                           | brownout_rst_i;
    assign rst_wake_pd = por_s | ext_rst_s | watchdog_rst_i
                         | (brownout_rst_i & bod_en);
    assign irq_wake = global_interrupt_enable_i
                      & (|(irq_pending_i & irq_enable_i));
    assign ext_wake = global_interrupt_enable_i
                      & (|(~ext_int_n_s & ext_int_en_i));
    assign kbd_wake = |(kbd_en & ~(kbd_prev_ff ^ kbd_entry_ff)
                        & (kbd_s ^ kbd_entry_ff));
    assign bod_wake = brownout_irq_i & bod_en;
    assign idle_wake = rst_wake_idle | irq_wake;
    assign pd_wake = rst_wake_pd | ext_wake | kbd_wake | watchdog_irq_i
                     | bod_wake;

    // Mode sequencer
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            PMC_RUN:
            begin
                if (power_control_wr && wb_dat_i[`PMC_PD_BIT])
                    nxt_state = PMC_PDOWN;
                else if (power_control_wr && wb_dat_i[`PMC_IDL_BIT])
                    nxt_state = PMC_IDLE;
            end
            PMC_IDLE:
            begin
                if (idle_wake)
                    nxt_state = PMC_RUN;
            end
            PMC_PDOWN:
            begin
                if (pd_wake)
                    nxt_state = PMC_OSC_WAIT;
            end
            PMC_OSC_WAIT:
            begin
                if (osc_cnt_ff == CNT_W'(1))
                    nxt_state = PMC_RELEASE;
            end
            PMC_RELEASE:
            begin
                nxt_state = PMC_RUN;
            end
            default:
            begin
                nxt_state = PMC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_ff <= PMC_RUN;
        else if (ce_i)
            state_ff <= nxt_state;
    end

    // Oscillator stabilisation count
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            osc_cnt_ff <= '0;
        else if (ce_i)
        begin
            if (state_ff == PMC_PDOWN)
                osc_cnt_ff <= CNT_W'(OSC_STABLE_CYC);
            else if (state_ff == PMC_OSC_WAIT)
                osc_cnt_ff <= osc_cnt_ff - CNT_W'(1);
        end
    end

    // Keyboard entry level capture
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            kbd_prev_ff <= '1;
            kbd_entry_ff <= '1;
        end
        else if (ce_i)
        begin
            kbd_prev_ff <= kbd_s;
            if (state_ff == PMC_RUN && nxt_state == PMC_PDOWN)
                kbd_entry_ff <= kbd_s;
        end
    end

    // Power control register
    always_comb
    begin
        nxt_power_control = power_control_ff;
        if (power_control_wr)
            nxt_power_control = (wb_dat_i[7:0] & `PMC_POWER_CONTROL_WMASK)
                       | (power_control_ff & ~`PMC_POWER_CONTROL_WMASK);
        if (state_ff == PMC_IDLE && idle_wake)
            nxt_power_control[`PMC_IDL_BIT] = 1'b0;
        if (state_ff == PMC_PDOWN && pd_wake)
        begin
            nxt_power_control[`PMC_PD_BIT] = 1'b0;
            nxt_power_control[`PMC_IDL_BIT] = 1'b0;
        end
        if (por_s)
            nxt_power_control[`PMC_POF_BIT] = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            power_control_ff <= `PMC_POWER_CONTROL_RST;
        else if (ce_i)
            power_control_ff <= nxt_power_control;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_mask_ff <= `PMC_IRQ_MASK_RST;
            wake_cfg_ff <= `PMC_WAKE_CFG_RST;
        end
        else if (ce_i)
        begin
            if (mask_wr)
                irq_mask_ff <= wb_dat_i[`PMC_EVT_W-1:0];
            if (cfg_wr && wb_sel_i[0])
                wake_cfg_ff[7:0] <= wb_dat_i[7:0];
            if (cfg_wr && wb_sel_i[1])
                wake_cfg_ff[8] <= wb_dat_i[8];
        end
    end

    // Clock and hold controls
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clk_ctl_ff <= '{osc_en: 1'b1, periph_en: 1'b1, cpu_en: 1'b1};
            port_hold_ff <= 1'b0;
            flash_stop_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            clk_ctl_ff.osc_en <= (nxt_state != PMC_PDOWN);
            clk_ctl_ff.periph_en <= (nxt_state == PMC_RUN)
                                    || (nxt_state == PMC_IDLE)
                                    || (nxt_state == PMC_RELEASE);
            clk_ctl_ff.cpu_en <= (nxt_state == PMC_RUN);
            port_hold_ff <= (nxt_state != PMC_RUN);
            flash_stop_ff <= (nxt_state == PMC_PDOWN)
                             || (nxt_state == PMC_OSC_WAIT);
        end
    end

    // Watchdog clear and restart pulses
    logic mode_enter;
    logic mode_leave;

    assign mode_enter = (state_ff == PMC_RUN) && (nxt_state != PMC_RUN);
    assign mode_leave = ((state_ff == PMC_IDLE) && (nxt_state == PMC_RUN))
                        || ((state_ff == PMC_PDOWN)
                            && (nxt_state == PMC_OSC_WAIT));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wdt_clr_ff <= 1'b0;
            cpu_reinit_ff <= 1'b0;
            reinit_pend_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            // Watchdog clear on entry and wake
            wdt_clr_ff <= mode_enter | mode_leave;
            // Pin or power-on reset restarts CPU
            if (state_ff == PMC_PDOWN && pd_wake)
                reinit_pend_ff <= por_s | ext_rst_s;
            cpu_reinit_ff <= (state_ff == PMC_RELEASE) & reinit_pend_ff;
        end
    end

    // Wake source capture
    always_comb
    begin
        nxt_wake_src = wake_src_ff;
        if (state_ff == PMC_IDLE && idle_wake)
        begin
            nxt_wake_src = '0;
            nxt_wake_src.reset = rst_wake_idle;
            nxt_wake_src.interrupt = irq_wake;
        end
        else if (state_ff == PMC_PDOWN && pd_wake)
        begin
            nxt_wake_src = '0;
            nxt_wake_src.reset = rst_wake_pd;
            nxt_wake_src.ext_pin = ext_wake;
            nxt_wake_src.keyboard = kbd_wake;
            nxt_wake_src.watchdog = watchdog_irq_i;
            nxt_wake_src.brownout = bod_wake;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wake_src_ff <= '0;
        else if (ce_i)
            wake_src_ff <= nxt_wake_src;
    end

    // Event status, write one to clear, set wins
    logic [`PMC_EVT_W-1:0] evt;

    always_comb
    begin
        evt = '0;
        evt[`PMC_EVT_IDLE_ENTER] = (state_ff == PMC_RUN)
                                   && (nxt_state == PMC_IDLE);
        evt[`PMC_EVT_PD_ENTER] = (state_ff == PMC_RUN)
                                 && (nxt_state == PMC_PDOWN);
        evt[`PMC_EVT_WAKE] = mode_leave;
        evt[`PMC_EVT_RESET_WAKE] = mode_leave & nxt_wake_src.reset;
        nxt_irq_stat = irq_stat_ff;
        if (stat_wr)
            nxt_irq_stat = irq_stat_ff & ~wb_dat_i[`PMC_EVT_W-1:0];
        nxt_irq_stat = nxt_irq_stat | evt;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat_ff <= '0;
            irq_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            irq_stat_ff <= nxt_irq_stat;
            irq_ff <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

    // Wishbone answer, one wait state, unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            rdata_ff <= '0;
        end
        else if (ce_i)
        begin
            ack_ff <= req;
            if (req && !wb_we_i)
            begin
                rdata_ff <= '0;
                if (idx_hit)
                begin
                    unique case (idx)
                        `PMC_POWER_CONTROL_IDX:
                            rdata_ff[7:0] <= power_control_ff;
                        `PMC_IRQ_STAT_IDX:
                            rdata_ff[`PMC_EVT_W-1:0] <= irq_stat_ff;
                        `PMC_IRQ_MASK_IDX:
                            rdata_ff[`PMC_EVT_W-1:0] <= irq_mask_ff;
                        `PMC_WAKE_CFG_IDX:
                            rdata_ff[8:0] <= wake_cfg_ff;
                        `PMC_STATE_IDX:
                            rdata_ff[8:0] <= {wake_src_ff, state_ff};
                        default:
                            rdata_ff <= '0;
                    endcase
                end
            end
        end
    end

    assign wb_dat_o = rdata_ff;
    assign wb_ack_o = ack_ff;
    assign clk_ctl_o = clk_ctl_ff;
    assign port_hold_o = port_hold_ff;
    assign flash_stop_o = flash_stop_ff;
    assign watchdog_counter_clr_o = wdt_clr_ff;
    assign cpu_reinit_o = cpu_reinit_ff;
    assign wake_src_o = wake_src_ff;
    assign baud_doubler_o = power_control_ff[7];
    assign pmc_irq_o = irq_ff;

    // Software reset is deliberately not a wake source
    logic unused_sw_rst;
    assign unused_sw_rst = sw_rst_i;

endmodule

// [pmc_cpu_model.sv]
// CPU core stand-in: counts fetches while its clock runs
`timescale 1ns/100ps
module pmc_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pmc_pkg::pmc_clk_ctl_t clk_ctl_i,
    input wire logic cpu_reinit_i,
    output logic [15:0] fetch_cnt_o
);
    import pmc_pkg::*;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || cpu_reinit_i)
            fetch_cnt_o <= 16'h0000;
        else if (clk_ctl_i.cpu_en)
            fetch_cnt_o <= fetch_cnt_o + 16'h0001;
    end
endmodule

// [pmc_assertions.sv]
// Port checks for the power-mode controller
`timescale 1ns/100ps
module pmc_checker #(
    parameter int OSC_STABLE_CYC = 1000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire pmc_pkg::pmc_clk_ctl_t clk_ctl_o,
    input wire logic port_hold_o,
    input wire logic flash_stop_o,
    input wire logic watchdog_counter_clr_o,
    input wire logic cpu_reinit_o
);
    import pmc_pkg::*;
    logic [15:0] osc_wait_ff;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);
    // Cycles spent with oscillator on and peripherals still stopped
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !clk_ctl_o.osc_en || clk_ctl_o.periph_en)
            osc_wait_ff <= 16'h0000;
        else
            osc_wait_ff <= osc_wait_ff + 16'h0001;
    end
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_pd_clocks_off: assert property (
        !clk_ctl_o.osc_en |-> !clk_ctl_o.periph_en && !clk_ctl_o.cpu_en)
        else $error("clock running with oscillator stopped");
    a_flash_stop: assert property (
        !clk_ctl_o.osc_en |-> flash_stop_o)
        else $error("flash not stopped in power-down");
    a_port_hold: assert property (!clk_ctl_o.cpu_en |-> port_hold_o)
        else $error("ports not held while cpu stopped");
    a_wd_clr_entry: assert property (
        $fell(clk_ctl_o.cpu_en) |-> ##[0:1] watchdog_counter_clr_o)
        else $error("no watchdog clear on mode entry");
    a_wd_clr_pdwake: assert property (
        $rose(clk_ctl_o.osc_en) |-> ##[0:1] watchdog_counter_clr_o)
        else $error("no watchdog clear on power-down wake");
    a_wd_clr_idlewake: assert property (
        $rose(clk_ctl_o.cpu_en) && $past(clk_ctl_o.periph_en, 2)
        |-> watchdog_counter_clr_o || $past(watchdog_counter_clr_o))
        else $error("no watchdog clear on idle wake");
    a_osc_settle: assert property (
        $rose(clk_ctl_o.periph_en) |-> osc_wait_ff >= OSC_STABLE_CYC)
        else $error("peripherals released before oscillator settled");
    a_osc_bound: assert property (osc_wait_ff <= OSC_STABLE_CYC + 3)
        else $error("oscillator wait too long");
    a_cpu_last: assert property (
        $rose(clk_ctl_o.periph_en) |-> !clk_ctl_o.cpu_en)
        else $error("cpu released with peripherals");
    c_idle: cover property (!clk_ctl_o.cpu_en && clk_ctl_o.periph_en);
    c_pdown: cover property (!clk_ctl_o.osc_en);
    c_reinit: cover property (cpu_reinit_o);
endmodule
bind pmc_power_mode_controller pmc_checker #(
    .OSC_STABLE_CYC(OSC_STABLE_CYC)
) i_pmc_checker (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .clk_ctl_o(clk_ctl_o),
    .port_hold_o(port_hold_o),
    .flash_stop_o(flash_stop_o),
    .watchdog_counter_clr_o(watchdog_counter_clr_o),
    .cpu_reinit_o(cpu_reinit_o)
);

// [tb.sv]
// Self-checking bench for the power-mode controller
`timescale 1ns/100ps
module tb;
    import pmc_pkg::*;
    localparam logic [11:0] POWER_CONTROL = 12'h21C;
    localparam logic [11:0] STAT = 12'h220;
    localparam logic [11:0] MASK = 12'h224;
    localparam logic [11:0] CFG = 12'h228;
    localparam logic [11:0] STATE = 12'h22C;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, port_hold_o, flash_stop_o, wd_clr, cpu_reinit_o;
    logic baud_doubler_o, pmc_irq_o, gie = 1'b0;
    logic [7:0] irq_pend = 8'h00, irq_en = 8'h00, kbd = 8'hFF;
    logic [1:0] ext_n = 2'h3;
    logic wd_irq = 1'b0, bo_irq = 1'b0, por = 1'b0, rst_n = 1'b1;
    logic wd_rst = 1'b0, sw_rst = 1'b0, bo_rst = 1'b0;
    pmc_clk_ctl_t clk_ctl_o;
    pmc_wake_src_t wake_src_o;
    logic [15:0] fetch_cnt, fc;
    logic [31:0] rdv;
    int miscompares = 0, num_checks = 0, reinit_cnt = 0, r0;

    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (cpu_reinit_o === 1'b1) reinit_cnt++;

    pmc_power_mode_controller #(.OSC_STABLE_CYC(4))
        i_pmc_power_mode_controller (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_pending_i(irq_pend), .irq_enable_i(irq_en),
        .global_interrupt_enable_i(gie), .ext_int_n_i(ext_n),
        .ext_int_en_i(2'h1), .keyboard_interrupt_pin_i(kbd),
        .watchdog_irq_i(wd_irq), .brownout_irq_i(bo_irq), .por_i(por),
        .ext_rst_n_i(rst_n), .watchdog_rst_i(wd_rst), .brownout_rst_i(bo_rst),
        .sw_rst_i(sw_rst), .clk_ctl_o(clk_ctl_o), .port_hold_o(port_hold_o),
        .flash_stop_o(flash_stop_o), .watchdog_counter_clr_o(wd_clr),
        .cpu_reinit_o(cpu_reinit_o), .wake_src_o(wake_src_o),
        .baud_doubler_o(baud_doubler_o), .pmc_irq_o(pmc_irq_o));
    pmc_cpu_model i_pmc_cpu_model (.clk_i(clk_i), .rst_i(rst_i),
        .clk_ctl_i(clk_ctl_o), .cpu_reinit_i(cpu_reinit_o),
        .fetch_cnt_o(fetch_cnt));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic xfer(input logic we, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        check("ack", 1, wb_ack_o);
        rdv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [11:0] a,
                      input logic [31:0] e, m);
        xfer(1'b0, a, 32'h0);
        check(nm, e, rdv & m);
    endtask
    task automatic stay(input string nm);
        hold(10);
        check(nm, 0, clk_ctl_o.cpu_en);
    endtask
    task automatic enter_pd(input logic [31:0] v);
        wr(POWER_CONTROL, v);
        check("pd_clk", 3'b000, clk_ctl_o);
        check("pd_flash", 1, flash_stop_o);
    endtask
    task automatic wake(input string nm, input int b);
        int n;
        n = 0;
        while (clk_ctl_o.cpu_en !== 1'b1 && n < 60)
        begin
            @(posedge clk_i);
            n++;
        end
        check("wake_wait", 1, clk_ctl_o.cpu_en);
        check(nm, 1, wake_src_o[b]);
        rd("pd_bits", POWER_CONTROL, 0, 3);
    endtask

    initial
    begin
        #(30000 * 100);
        miscompares++;
        complete_run();
    end
    initial
    begin
        hold(6);
        rst_i <= 1'b0;
        hold(1);
        rd("power_control_rst", POWER_CONTROL, 0, 32'hFF);
        rd("unmapped", 12'h300, 0, 32'hFFFFFFFF);
        rd("mask_rst", MASK, 0, 32'hF);
        wr(POWER_CONTROL, 32'hFC);
        rd("power_control_rw", POWER_CONTROL, 32'hDC, 32'hFF);
        check("baud", 1, baud_doubler_o);
        wr(POWER_CONTROL, 0);
        rd("pof_clr", POWER_CONTROL, 0, 32'h10);
        wr(MASK, 32'hF);
        $display("test registers done");
        irq_en <= 8'h00;
        gie <= 1'b1;
        wr(POWER_CONTROL, 1);
        check("idle_clk", 3'b110, clk_ctl_o);
        fc = fetch_cnt;
        irq_pend <= 8'h01;
        stay("idle_masked");
        check("idle_fetch", fc, fetch_cnt);
        check("irq_out", 1, pmc_irq_o);
        ce_i <= 1'b0;
        irq_en <= 8'h01;
        stay("ce_frozen");
        ce_i <= 1'b1;
        wake("idle_wake", 0);
        rd("state_word", STATE, 32'h008, 32'h1FF);
        irq_pend <= 8'h00;
        wr(POWER_CONTROL, 1);
        sw_rst <= 1'b1;
        stay("idle_swrst");
        sw_rst <= 1'b0;
        wd_rst <= 1'b1;
        wake("idle_rst", 5);
        wd_rst <= 1'b0;
        $display("test idle done");
        gie <= 1'b0;
        enter_pd(3);
        ext_n <= 2'h2;
        stay("pd_gie_off");
        ext_n <= 2'h1;
        hold(3);
        gie <= 1'b1;
        stay("pd_ext_dis");
        ext_n <= 2'h2;
        wake("pd_ext", 1);
        ext_n <= 2'h3;
        wr(CFG, 1);
        for (int l = 0; l < 2; l++)
        begin
            kbd[0] <= l[0];
            hold(3);
            enter_pd(2);
            kbd <= {7'h00, l[0]};
            stay("kbd_same");
            kbd[0] <= ~l[0];
            wake("kbd_edge", 2);
        end
        kbd <= 8'hFF;
        wr(CFG, 0);
        enter_pd(2);
        bo_irq <= 1'b1;
        bo_rst <= 1'b1;
        stay("bo_gated");
        wr(CFG, 32'h100);
        wake("pd_bo", 4);
        check("pd_bo_rst", 1, wake_src_o[5]);
        bo_irq <= 1'b0;
        bo_rst <= 1'b0;
        enter_pd(2);
        wd_irq <= 1'b1;
        wake("pd_wd", 3);
        wd_irq <= 1'b0;
        r0 = reinit_cnt;
        enter_pd(2);
        rst_n <= 1'b0;
        hold(3);
        rst_n <= 1'b1;
        wake("pd_pin", 5);
        check("reinit_pin", r0 + 1, reinit_cnt);
        enter_pd(2);
        por <= 1'b1;
        hold(3);
        por <= 1'b0;
        wake("pd_por", 5);
        check("reinit_por", r0 + 2, reinit_cnt);
        rd("pof_set", POWER_CONTROL, 32'h10, 32'h10);
        wr(POWER_CONTROL, 0);
        rd("pof_swclr", POWER_CONTROL, 0, 32'h10);
        $display("test power-down done");
        wr(MASK, 0);
        check("irq_masked", 0, pmc_irq_o);
        wr(MASK, 32'hF);
        check("irq_unmask", 1, pmc_irq_o);
        wr(STAT, 32'hF);
        rd("stat_clr", STAT, 0, 32'hF);
        check("irq_clr", 0, pmc_irq_o);
        $display("test interrupt done");
        complete_run();
    end
endmodule
